// ---- logic/rpst_consts.svh ----
// Timing constants for the reflected-power self-test sequencer.
// Assumes a single system clock whose period is RPST_CLK_NS.
`ifndef RPST_CONSTS_SVH
`define RPST_CONSTS_SVH

// System clock period in ns (100 MHz)
`define RPST_CLK_NS       10

// Self-test pulse width, 10 ms, in ns
`define RPST_PULSE_NS     10000000
// Latch-clear pulse width, 0.5 ms, in ns
`define RPST_CLEAR_NS     500000
// Clear release to capture edge, 100 ns
`define RPST_SKEW_NS      100
// Power-up hold rise to generator start, in ns
`define RPST_PWR_DLY_NS   1000

// Least times round up to whole cycles
`define RPST_CYC_UP(ns)   (((ns) + `RPST_CLK_NS - 1) / `RPST_CLK_NS)

// Cycle counts derived from the times above
`define RPST_PULSE_CYC    `RPST_CYC_UP(`RPST_PULSE_NS)
`define RPST_CLEAR_CYC    `RPST_CYC_UP(`RPST_CLEAR_NS)
`define RPST_SKEW_CYC     `RPST_CYC_UP(`RPST_SKEW_NS)
`define RPST_PWR_DLY_CYC  `RPST_CYC_UP(`RPST_PWR_DLY_NS)

// Reset values
`define RPST_RESULT_RST   1'b0
`define RPST_TRIG_RST     1'b1
`define RPST_PWR_RST      1'b0

`endif

// ---- logic/rpst_pkg.sv ----
// Types shared by the reflected-power self-test sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
package rpst_pkg;

	// Sequence phases, one-hot
	typedef enum logic [3:0]
	{
		S_IDLE  = 4'h1,
		S_CLEAR = 4'h2,
		S_SKEW  = 4'h4,
		S_WAIT  = 4'h8
	} rpst_state_t;

	// Which generator started the running test
	typedef enum logic
	{
		SRC_MANUAL = 1'b0,
		SRC_POWER  = 1'b1
	} rpst_src_t;

endpackage : rpst_pkg

// ---- logic/rpst_self_test.sv ----
// Self-test sequencer for the reflected-power fault logic.
// Assumes all inputs synchronous to sys_clk; srst is synchronous.
//
// Summary of operation
// - Button or external request gives one low trigger
// - Trigger falling edge starts manual generator
// - Manual generator gives complementary 10 ms pulses
// - Delayed power-up hold rise starts power-up generator
// - Power-up generator gives same 10 ms pulses
// - Monitor pulse low while either generator active
// - Each test gives one 0.5 ms clear
// - Clear falls with pulse, rises after 0.5 ms
// - Result cleared when monitor pulse begins
// - Clear low holds true low, complement high
// - Data captured 100 ns after clear release
// - Clear released before the capture edge
// - Red on, green off during clear
// - Data high at capture: pass, green
// - Data low at capture: fail, red
// - Fail stays latched until a later pass
// - Remote fail high on fail, low on pass
`timescale 1ns/1ps
`include "rpst_consts.svh"

module rpst_self_test #(
	parameter int PULSE_CYC   = `RPST_PULSE_CYC,   // 10 ms pulse
	parameter int CLEAR_CYC   = `RPST_CLEAR_CYC,   // 0.5 ms clear
	parameter int PWR_DLY_CYC = `RPST_PWR_DLY_CYC  // Power-up delay
)(
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic srst,
	// Trigger sources
	input  wire logic manualTestButtonN,
	input  wire logic extTestRequestN,
	input  wire logic powerUpHold,
	// Fault-detect result
	input  wire logic reflectedHitDetect,
	// Pulse generator outputs
	output logic      manualPulse,
	output logic      manualPulseN,
	output logic      powerPulse,
	output logic      powerPulseN,
	// Monitor drive and latch clear
	output logic      monitorTestPulseN,
	output logic      latchClearPulseN,
	// Result latch and indicators
	output logic      resultQ,
	output logic      resultQN,
	output logic      redLedOn,
	output logic      greenLedOn,
	output logic      remoteTestFail
);
	import rpst_pkg::*;

	// Counter widths
	localparam int PW = $clog2(PULSE_CYC + 1);
	localparam int CW = $clog2(CLEAR_CYC + 1);
	localparam int DW = $clog2(PWR_DLY_CYC + 1);
	localparam int SKEW_CYC = `RPST_SKEW_CYC;

	// Terminal counts at counter width
	localparam logic [PW-1:0] PULSE_LAST = PW'(PULSE_CYC - 1);
	localparam logic [CW-1:0] CLEAR_LAST = CW'(CLEAR_CYC - 1);
	localparam logic [CW-1:0] SKEW_LAST  = CW'(SKEW_CYC - 1);
	localparam logic [DW-1:0] DLY_LOAD   = DW'(PWR_DLY_CYC);
	localparam logic [DW-1:0] DLY_ONE    = DW'(1);

	// Sequence state and counters
	rpst_state_t     state_q;    // Current phase
	rpst_src_t       src_q;      // Starting generator
	logic [PW-1:0]   pulseCnt_q; // Cycles into pulse
	logic [CW-1:0]   phaseCnt_q; // Cycles into phase

	// Trigger detection
	logic            trigN;      // Combined low trigger
	logic            trigPrev_q; // Trigger last cycle
	logic            manualFall; // Manual start event
	logic            pwrPrev_q;  // Hold last cycle
	logic [DW-1:0]   pwrDly_q;   // Power-up delay count
	logic            pwrFire;    // Power-up start event

	// Sequence decode
	logic            idle;       // No test running
	logic            startReq;   // Accepted start
	logic            pulseEnd;   // Last pulse cycle
	logic            capture;    // Latch clock edge

	// Generator and latch flops
	logic            manPulse_q; // Manual generator out
	logic            pwrPulse_q; // Power-up generator out
	logic            result_q;   // Result latch true out

	// Either source pulls the trigger low
	assign trigN = manualTestButtonN & extTestRequestN;

	// Previous trigger level for edge detection
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			trigPrev_q <= `RPST_TRIG_RST;
		else
			trigPrev_q <= trigN;
	end

	// High-to-low trigger transition
	assign manualFall = trigPrev_q & ~trigN;

	// Previous power-up hold level
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			pwrPrev_q <= `RPST_PWR_RST;
		else
			pwrPrev_q <= powerUpHold;
	end

	// Delay the hold rise so the generators settle first
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			pwrDly_q <= '0;
		// Rising hold loads the delay
		else if (powerUpHold && !pwrPrev_q)
			pwrDly_q <= DLY_LOAD;
		// Count down to the start
		else if (pwrDly_q != '0)
			pwrDly_q <= pwrDly_q - DLY_ONE;
	end

	// Delayed rising edge fires power-up generator
	assign pwrFire = (pwrDly_q == DLY_ONE);

	// Phase decode
	assign idle     = (state_q == S_IDLE);
	assign startReq = idle && (manualFall || pwrFire);
	assign pulseEnd = (state_q == S_WAIT) && (pulseCnt_q == PULSE_LAST);
	assign capture  = (state_q == S_SKEW) && (phaseCnt_q == SKEW_LAST);

	// Phase sequencing
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			state_q <= S_IDLE;
		else
		begin
			unique case (state_q)
				// Wait for an accepted trigger
				S_IDLE:
				begin
					if (startReq)
						state_q <= S_CLEAR;
				end
				// Hold clear for 0.5 ms
				S_CLEAR:
				begin
					if (phaseCnt_q == CLEAR_LAST)
						state_q <= S_SKEW;
				end
				// Clear released, wait 100 ns
				S_SKEW:
				begin
					if (capture)
						state_q <= S_WAIT;
				end
				// Rest of the 10 ms pulse
				S_WAIT:
				begin
					if (pulseEnd)
						state_q <= S_IDLE;
				end
			endcase
		end
	end

	// Cycles within the clear and skew phases
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			phaseCnt_q <= '0;
		// Restart at each phase change
		else if (idle || (state_q == S_WAIT))
			phaseCnt_q <= '0;
		else if ((state_q == S_CLEAR) && (phaseCnt_q == CLEAR_LAST))
			phaseCnt_q <= '0;
		else
			phaseCnt_q <= phaseCnt_q + CW'(1);
	end

	// Cycles since the pulse began
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			pulseCnt_q <= '0;
		else if (idle)
			pulseCnt_q <= '0;
		else
			pulseCnt_q <= pulseCnt_q + PW'(1);
	end

	// Remember which generator started the test
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			src_q <= SRC_MANUAL;
		// Power-up wins a tie
		else if (startReq)
			src_q <= pwrFire ? SRC_POWER : SRC_MANUAL;
	end

	// Manual generator pulse
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			manPulse_q <= 1'b0;
		else if (startReq && !pwrFire)
			manPulse_q <= 1'b1;
		else if (pulseEnd)
			manPulse_q <= 1'b0;
	end

	// Power-up generator pulse
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			pwrPulse_q <= 1'b0;
		else if (startReq && pwrFire)
			pwrPulse_q <= 1'b1;
		else if (pulseEnd)
			pwrPulse_q <= 1'b0;
	end

	// Result latch: cleared at start, clocked after skew
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			result_q <= `RPST_RESULT_RST;
		// Clear with the start of the monitor pulse
		else if (startReq)
			result_q <= 1'b0;
		// Store detect level at the capture edge
		else if (capture)
			result_q <= reflectedHitDetect;
	end

	// Complementary generator outputs
	assign manualPulse  = manPulse_q;
	assign manualPulseN = ~manPulse_q;
	assign powerPulse   = pwrPulse_q;
	assign powerPulseN  = ~pwrPulse_q;

	// Either generator drives the monitor low
	assign monitorTestPulseN = manualPulseN & powerPulseN;

	// Clear is low only in the clear phase
	assign latchClearPulseN = (state_q != S_CLEAR);

	// Latch outputs and indicators
	assign resultQ        = result_q;
	assign resultQN       = ~result_q;
	assign greenLedOn     = result_q;
	assign redLedOn       = ~result_q;
	assign remoteTestFail = ~result_q;

	// Checks on the sequence

	// Helper: length of current monitor pulse
	logic [PW-1:0] lowLen_q;
	always_ff @(posedge sys_clk)
	begin
		if (srst || monitorTestPulseN)
			lowLen_q <= '0;
		else
			lowLen_q <= lowLen_q + PW'(1);
	end

	// Helper: length of current clear pulse
	logic [CW-1:0] clrLen_q;
	always_ff @(posedge sys_clk)
	begin
		if (srst || latchClearPulseN)
			clrLen_q <= '0;
		else
			clrLen_q <= clrLen_q + CW'(1);
	end

	// Test begins: monitor pulse falls
	sequence seqStart;
		$fell(monitorTestPulseN);
	endsequence

	// Clear released
	sequence seqRelease;
		$rose(latchClearPulseN);
	endsequence

	a_trig_starts: assert property (@(posedge sys_clk) disable iff (srst)
		(monitorTestPulseN && $fell(trigN) && pwrDly_q != DLY_ONE)
		|=> !manualPulseN && !monitorTestPulseN)
		else $error("manual trigger did not start test");
	a_clear_at_start: assert property (@(posedge sys_clk) disable iff (srst)
		seqStart |-> !latchClearPulseN && !resultQ && resultQN)
		else $error("clear or latch not set at test start");
	a_clear_length: assert property (@(posedge sys_clk) disable iff (srst)
		seqRelease |-> ($past(clrLen_q) == CLEAR_LAST) && !monitorTestPulseN)
		else $error("clear pulse length wrong");
	a_capture_skew: assert property (@(posedge sys_clk) disable iff (srst)
		seqRelease ##SKEW_CYC 1'b1 |-> resultQ == $past(reflectedHitDetect))
		else $error("result not captured after skew");
	a_clear_hold: assert property (@(posedge sys_clk) disable iff (srst)
		!latchClearPulseN |-> redLedOn && !greenLedOn && !resultQ)
		else $error("indicators wrong during clear");
	a_pulse_length: assert property (@(posedge sys_clk) disable iff (srst)
		$rose(monitorTestPulseN) |-> $past(lowLen_q) == PULSE_LAST)
		else $error("self-test pulse length wrong");
	a_one_clear: assert property (@(posedge sys_clk) disable iff (srst)
		!monitorTestPulseN |=> !$fell(latchClearPulseN))
		else $error("second clear within one test");
	a_result_hold: assert property (@(posedge sys_clk) disable iff (srst)
		$changed(resultQ) |-> $fell(monitorTestPulseN) || $past(capture))
		else $error("result changed outside a test");
	a_mon_either: assert property (@(posedge sys_clk) disable iff (srst)
		!monitorTestPulseN |-> (manualPulse ^ powerPulse) && (manualPulseN ^ powerPulseN))
		else $error("monitor pulse without one generator");
	a_gen_source: assert property (@(posedge sys_clk) disable iff (srst)
		!monitorTestPulseN |-> powerPulse == (src_q == SRC_POWER))
		else $error("pulse from wrong generator");
	a_remote_fail: assert property (@(posedge sys_clk) disable iff (srst)
		capture |=> remoteTestFail == !$past(reflectedHitDetect))
		else $error("remote fail disagrees with capture");

endmodule // rpst_self_test

// ---- dv/rpst_monitor_model.sv ----
// Behavioural output monitor and fault-detect path for the self-test.
// Assumes the test pulse is synchronous to the sequencer clock.
`timescale 1ns/1ps

module rpst_monitor_model (
	// Self-test drive from the sequencer
	input  wire logic monitorTestPulseN,
	// Fault injection, high breaks the detector path
	input  wire logic pathBroken,
	// Fault-detect data back to the latch
	output logic      reflectedHitDetect
);
	// Hit injected while the pulse is low, seen unless the path is broken
	assign reflectedHitDetect = ~monitorTestPulseN & ~pathBroken;
endmodule // rpst_monitor_model

// ---- dv/rpst_self_test_tb_top.sv ----
// Self-checking bench for the reflected-power self-test sequencer.
// Assumes shortened counts; a result queue is checked at each capture.
`timescale 1ns/1ps

module rpst_self_test_tb_top;
	import rpst_pkg::*;
	localparam int PULSE_CYC = 200;    // Shortened 10 ms pulse
	localparam int CLEAR_CYC = 20;     // Shortened clear
	localparam int PWR_DLY_CYC = 5;    // Shortened power-up delay
	localparam int SKEW_CYC = 10;      // Clear release to capture
	logic sys_clk = 1'b0;
	logic srst = 1'b1;
	logic btnN = 1'b1;
	logic extN = 1'b1;
	logic pwrHold = 1'b0;
	logic broken = 1'b0;
	logic hit, mP, mPN, pP, pPN, monN, clrN, resQ, resQN, red, green, remote;
	int failures = 0;
	int cmp_count = 0;
	int seed = 320;
	int clrCnt = 0;      // Cycles clear seen low
	int pulseCnt = 0;    // Cycles monitor pulse seen low
	int capCnt = 0;      // Countdown to capture
	logic expQ[$];       // Expected pass flags

	// Clock
	always #5 sys_clk = ~sys_clk;

	rpst_self_test #(.PULSE_CYC(PULSE_CYC), .CLEAR_CYC(CLEAR_CYC), .PWR_DLY_CYC(PWR_DLY_CYC))
	rpst_self_test_i (.sys_clk(sys_clk), .srst(srst), .manualTestButtonN(btnN),
		.extTestRequestN(extN), .powerUpHold(pwrHold), .reflectedHitDetect(hit),
		.manualPulse(mP), .manualPulseN(mPN), .powerPulse(pP), .powerPulseN(pPN),
		.monitorTestPulseN(monN), .latchClearPulseN(clrN), .resultQ(resQ), .resultQN(resQN),
		.redLedOn(red), .greenLedOn(green), .remoteTestFail(remote));

	rpst_monitor_model rpst_monitor_model_i (.monitorTestPulseN(monN), .pathBroken(broken),
		.reflectedHitDetect(hit));

	// Compare and count
	task automatic check(input logic seen, input logic exp, input string what);
		cmp_count++;
		if (seen !== exp)
		begin
			failures++;
			$display("Error at %0t: %s", $time, what);
		end
	endtask

	// Counts, verdict and end of run
	task automatic summarize();
		$display("Compares %0d, mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Assert or release a trigger source: 0 button, 1 request, 2 both button and request, 3 power-up hold
	task automatic drive(input int src, input logic on);
		if (src == 3)
			pwrHold <= on;
		else
		begin
			btnN <= ~(on && src != 1);
			extN <= ~(on && src != 0);
		end
	endtask

	// One test with a retrigger in mid-run
	task automatic run_test(input int src, input logic bad);
		int n;
		@(posedge sys_clk);
		broken <= bad;
		expQ.push_back(~bad);
		drive(src, 1'b1);
		repeat ((src == 3) ? PWR_DLY_CYC : 0) @(posedge sys_clk);
		#1;
		check(monN, 1'b1, "early start");
		@(posedge sys_clk);
		#1;
		check(monN, 1'b0, "no start");
		check((src == 3) ? pP : mP, 1'b1, "wrong generator");
		check((src == 3) ? mP : pP, 1'b0, "both generators");
		repeat (5) @(posedge sys_clk);
		drive(src, 1'b0);
		repeat (40) @(posedge sys_clk);
		drive(src, 1'b1);
		repeat (3) @(posedge sys_clk);
		drive(src, 1'b0);
		n = 0;
		while (monN !== 1'b1 && n < PULSE_CYC + 50)
		begin
			@(posedge sys_clk);
			n++;
		end
		check(n < PULSE_CYC + 50, 1'b1, "pulse never ended");
		repeat (15) @(posedge sys_clk);
		#1;
		check(resQ, ~bad, "result not held");
		$display("Test done: source %0d broken %0d", src, bad);
	endtask

	// Output watcher: widths, pairs, clear state and capture
	always @(posedge sys_clk)
	begin
		#1;
		check(mPN, ~mP, "manual pair");
		check(pPN, ~pP, "power pair");
		check(monN, mPN & pPN, "monitor pulse");
		if (!monN)
			pulseCnt++;
		else if (pulseCnt != 0)
		begin
			check(pulseCnt == PULSE_CYC, 1'b1, "pulse width");
			pulseCnt = 0;
		end
		if (!clrN)
		begin
			clrCnt++;
			check(resQ | ~resQN, 1'b0, "latch not cleared");
			check(red & ~green, 1'b1, "clear leds");
		end
		else if (clrCnt != 0)
		begin
			check(clrCnt == CLEAR_CYC, 1'b1, "clear width");
			clrCnt = 0;
			capCnt = SKEW_CYC + 1;
		end
		if (capCnt > 0)
		begin
			capCnt--;
			if (capCnt != 0)
				check(resQ, 1'b0, "early capture");
			else if (expQ.size() == 0)
				check(1'b0, 1'b1, "unexpected result");
			else
			begin
				check(resQ, expQ[0], "result");
				check(green, expQ[0], "green led");
				check(red, ~expQ[0], "red led");
				check(resQN, ~expQ[0], "result inverse");
				check(remote, ~expQ.pop_front(), "remote fail");
			end
		end
	end

	// Main sequence
	initial
	begin
		repeat (20) @(posedge sys_clk);
		srst <= 1'b0;
		@(posedge sys_clk);
		#1;
		check(remote, 1'b1, "reset result");
		run_test(0, 1'b1);
		run_test(0, 1'b0);
		for (int i = 0; i < 8; i++)
			run_test(i % 4, 1'($random(seed)));
		check(expQ.size() == 0, 1'b1, "missing result");
		summarize();
	end

	// Watchdog
	initial
	begin
		// Ten tests of one pulse plus margin each, fourfold
		repeat (4 * (30 + 10 * (PULSE_CYC + 100))) @(posedge sys_clk);
		failures++;
		$display("Error at %0t: timeout", $time);
		summarize();
	end
endmodule // rpst_self_test_tb_top
